// [verilog/rcos_cfg.svh]
// Register map, field layout and reset values for the recovered clock output select block
`ifndef RCOS_CFG_SVH
`define RCOS_CFG_SVH
`define RCOS_ADDR_W 8
`define RCOS_IDX_SEL_2_3 8'hd3
`define RCOS_IDX_SEL_4_5 8'hd4
`define RCOS_IDX_SEL_6_7 8'hd5
`define RCOS_IDX_SEL_8_MUX 8'hd6
`define RCOS_IDX_LEGACY 8'hd7
`define RCOS_RST_SEL_2_3 8'h21
`define RCOS_RST_SEL_4_5 8'h43
`define RCOS_RST_SEL_6_7 8'h65
`define RCOS_RST_SEL_8_MUX 8'h07
`define RCOS_RST_LEGACY 8'h00
`define RCOS_MASK_SEL_PAIR 8'h77
`define RCOS_MASK_SEL_8_MUX 8'h17
`define RCOS_MASK_LEGACY 8'h01
`define RCOS_LO_MSB 2
`define RCOS_LO_LSB 0
`define RCOS_HI_MSB 6
`define RCOS_HI_LSB 4
`define RCOS_MUX16_BIT 4
`define RCOS_LEGACY_BIT 0
`define RCOS_UNMAPPED_DATA 32'h00000000
`endif

// [verilog/rcos_pkg.sv]
// Types for the recovered clock output select block
package rcos_pkg;
  typedef logic [2:0] rcos_sel_type;
  typedef logic [7:0] rcos_chan_type;
  typedef enum logic [1:0] {
    RCOS_IDLE = 2'b01,
    RCOS_ANSWER = 2'b10
  } rcos_bus_state_type;
endpackage

// [verilog/rcos_select.sv]
// Recovered clock output selection with Avalon-MM register access
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
`include "rcos_cfg.svh"
module rcos_select
  import rcos_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [7:0] channel_clock_in,
  output logic recovered_clock_out_2,
  output logic recovered_clock_out_3,
  output logic recovered_clock_out_4,
  output logic recovered_clock_out_5,
  output logic recovered_clock_out_6,
  output logic recovered_clock_out_7,
  output logic recovered_clock_out_8,
  output logic sys_mux_16m_mode_out
);

  function automatic logic pick(input rcos_chan_type chans, input rcos_sel_type code,
                                input logic legacy, input rcos_sel_type fixed);
    rcos_sel_type idx;
    idx = legacy ? fixed : code;
    pick = chans[idx];
  endfunction

  function automatic logic hits(input logic [7:0] addr, input logic [7:0] idx);
    hits = (addr == idx);
  endfunction

  // Writable bits only
  function automatic logic [7:0] keep_bits(input logic [7:0] data, input logic [7:0] mask);
    keep_bits = data & mask;
  endfunction

  rcos_bus_state_type state;
  rcos_bus_state_type next_state;
  logic [7:0] sel_2_3;
  logic [7:0] sel_4_5;
  logic [7:0] sel_6_7;
  logic [7:0] sel_8_mux;
  logic [7:0] legacy_reg;
  logic [7:0] chan_meta;
  logic [7:0] chan_sync;
  logic [31:0] next_readdata;

  wire logic req = avs_read_in | avs_write_in;
  wire logic take = req && (state == RCOS_IDLE);
  wire logic wr_lane0 = take && avs_write_in && avs_byteenable_in[0];
  wire logic hit_2_3 = hits(avs_address_in, `RCOS_IDX_SEL_2_3);
  wire logic hit_4_5 = hits(avs_address_in, `RCOS_IDX_SEL_4_5);
  wire logic hit_6_7 = hits(avs_address_in, `RCOS_IDX_SEL_6_7);
  wire logic hit_8_mux = hits(avs_address_in, `RCOS_IDX_SEL_8_MUX);
  wire logic hit_legacy = hits(avs_address_in, `RCOS_IDX_LEGACY);
  wire logic wr_2_3 = wr_lane0 && hit_2_3;
  wire logic wr_4_5 = wr_lane0 && hit_4_5;
  wire logic wr_6_7 = wr_lane0 && hit_6_7;
  wire logic wr_8_mux = wr_lane0 && hit_8_mux;
  wire logic wr_legacy = wr_lane0 && hit_legacy;
  wire logic [7:0] wbyte = avs_writedata_in[7:0];
  wire logic [7:0] next_sel_2_3 = keep_bits(wbyte, `RCOS_MASK_SEL_PAIR);
  wire logic [7:0] next_sel_4_5 = keep_bits(wbyte, `RCOS_MASK_SEL_PAIR);
  wire logic [7:0] next_sel_6_7 = keep_bits(wbyte, `RCOS_MASK_SEL_PAIR);
  wire logic [7:0] next_sel_8_mux = keep_bits(wbyte, `RCOS_MASK_SEL_8_MUX);
  wire logic [7:0] next_legacy_reg = keep_bits(wbyte, `RCOS_MASK_LEGACY);
  wire logic [7:0] rbyte =
    hit_2_3 ? sel_2_3 :
    hit_4_5 ? sel_4_5 :
    hit_6_7 ? sel_6_7 :
    hit_8_mux ? sel_8_mux :
    hit_legacy ? legacy_reg : 8'h00;

  // Output source selection
  wire logic legacy = legacy_reg[`RCOS_LEGACY_BIT];
  wire logic [2:0] code_2 = sel_2_3[`RCOS_LO_MSB:`RCOS_LO_LSB];
  wire logic [2:0] code_3 = sel_2_3[`RCOS_HI_MSB:`RCOS_HI_LSB];
  wire logic [2:0] code_4 = sel_4_5[`RCOS_LO_MSB:`RCOS_LO_LSB];
  wire logic [2:0] code_5 = sel_4_5[`RCOS_HI_MSB:`RCOS_HI_LSB];
  wire logic [2:0] code_6 = sel_6_7[`RCOS_LO_MSB:`RCOS_LO_LSB];
  wire logic [2:0] code_7 = sel_6_7[`RCOS_HI_MSB:`RCOS_HI_LSB];
  wire logic [2:0] code_8 = sel_8_mux[`RCOS_LO_MSB:`RCOS_LO_LSB];
  wire logic next_out_2 = pick(chan_sync, code_2, legacy, 3'h1);
  wire logic next_out_3 = pick(chan_sync, code_3, legacy, 3'h2);
  wire logic next_out_4 = pick(chan_sync, code_4, legacy, 3'h3);
  wire logic next_out_5 = pick(chan_sync, code_5, legacy, 3'h4);
  wire logic next_out_6 = pick(chan_sync, code_6, legacy, 3'h5);
  wire logic next_out_7 = pick(chan_sync, code_7, legacy, 3'h6);
  wire logic next_out_8 = pick(chan_sync, code_8, legacy, 3'h7);
  wire logic next_mux16 = sel_8_mux[`RCOS_MUX16_BIT];

  assign next_state = take ? RCOS_ANSWER : RCOS_IDLE;
  assign next_readdata = (take && avs_read_in) ? {24'h000000, rbyte} : `RCOS_UNMAPPED_DATA;

  // Bus handshake: waitrequest drops for one cycle after a request is seen
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state <= RCOS_IDLE;
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h00000000;
    end
    else
    begin
      case (state)
        RCOS_IDLE:
        begin
          state <= next_state;
          avs_waitrequest_out <= ~take;
          avs_readdata_out <= next_readdata;
        end
        RCOS_ANSWER:
        begin
          state <= RCOS_IDLE;
          avs_waitrequest_out <= 1'b1;
          avs_readdata_out <= 32'h00000000;
        end
        default:
        begin
          state <= RCOS_IDLE;
          avs_waitrequest_out <= 1'b1;
          avs_readdata_out <= 32'h00000000;
        end
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sel_2_3 <= `RCOS_RST_SEL_2_3;
    end
    else
    begin
      if (wr_2_3)
      begin
        sel_2_3 <= next_sel_2_3;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sel_4_5 <= `RCOS_RST_SEL_4_5;
    end
    else
    begin
      if (wr_4_5)
      begin
        sel_4_5 <= next_sel_4_5;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sel_6_7 <= `RCOS_RST_SEL_6_7;
    end
    else
    begin
      if (wr_6_7)
      begin
        sel_6_7 <= next_sel_6_7;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sel_8_mux <= `RCOS_RST_SEL_8_MUX;
    end
    else
    begin
      if (wr_8_mux)
      begin
        sel_8_mux <= next_sel_8_mux;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      legacy_reg <= `RCOS_RST_LEGACY;
    end
    else
    begin
      if (wr_legacy)
      begin
        legacy_reg <= next_legacy_reg;
      end
    end
  end

  // Channel clocks pass two flip-flops
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      chan_meta <= 8'h00;
    end
    else
    begin
      chan_meta <= channel_clock_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      chan_sync <= 8'h00;
    end
    else
    begin
      chan_sync <= chan_meta;
    end
  end

  // Registered outputs
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      recovered_clock_out_2 <= 1'b0;
    end
    else
    begin
      recovered_clock_out_2 <= next_out_2;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      recovered_clock_out_3 <= 1'b0;
    end
    else
    begin
      recovered_clock_out_3 <= next_out_3;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      recovered_clock_out_4 <= 1'b0;
    end
    else
    begin
      recovered_clock_out_4 <= next_out_4;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      recovered_clock_out_5 <= 1'b0;
    end
    else
    begin
      recovered_clock_out_5 <= next_out_5;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      recovered_clock_out_6 <= 1'b0;
    end
    else
    begin
      recovered_clock_out_6 <= next_out_6;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      recovered_clock_out_7 <= 1'b0;
    end
    else
    begin
      recovered_clock_out_7 <= next_out_7;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      recovered_clock_out_8 <= 1'b0;
    end
    else
    begin
      recovered_clock_out_8 <= next_out_8;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sys_mux_16m_mode_out <= 1'b0;
    end
    else
    begin
      sys_mux_16m_mode_out <= next_mux16;
    end
  end

endmodule

// [verification/rcos_sys_sink.sv]
// System-side model registering the selected recovered clocks
`timescale 1ns/1ps
module rcos_sys_sink (
  input wire logic clk_in,
  input wire logic [6:0] clocks_in,
  input wire logic mux_mode_in,
  input wire logic [1:0] rate_field_in,
  output logic [6:0] seen_out,
  output logic rate_ok_out
);
  always_ff @(posedge clk_in)
  begin
    seen_out <= clocks_in;
    rate_ok_out <= !mux_mode_in || (rate_field_in == 2'b11);
  end
endmodule

// [verification/rcos_checker.sv]
// Assertions on register bus answers and mux mode output
`timescale 1ns/1ps
`include "rcos_cfg.svh"
module rcos_checker (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic sys_mux_16m_mode_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_answer_one_cycle: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("answer too long");
  a_answer_in_time: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |-> ##[1:2] !avs_waitrequest_out) else $error("no answer");
  a_no_stray: assert property (!avs_waitrequest_out |-> $past(avs_read_in || avs_write_in))
    else $error("stray answer");
  a_upper_zero: assert property (!avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h0)
    else $error("upper bits set");
  a_reserved_zero: assert property (!avs_waitrequest_out |-> !avs_readdata_out[7]
    && !avs_readdata_out[3]) else $error("reserved bit set");
  a_mux_readback: assert property (!avs_waitrequest_out && $past(avs_read_in) &&
    $past(avs_address_in) == `RCOS_IDX_SEL_8_MUX
    |-> avs_readdata_out[4] == sys_mux_16m_mode_out)
    else $error("mux mode differs");
  a_mux_by_write: assert property ($changed(sys_mux_16m_mode_out) |-> $past(avs_write_in))
    else $error("mux changed alone");
  a_mux_other_reg: assert property (!avs_waitrequest_out && $past(avs_write_in) &&
    $past(avs_address_in) != `RCOS_IDX_SEL_8_MUX |=> $stable(sys_mux_16m_mode_out))
    else $error("mux changed by other write");
endmodule
bind rcos_select rcos_checker u_chk (.clk_in, .rst_n_in, .avs_address_in, .avs_read_in,
  .avs_write_in, .avs_readdata_out, .avs_waitrequest_out, .sys_mux_16m_mode_out);

// [verification/tb.sv]
// Self-checking bench for the recovered clock output select block
`timescale 1ns/1ps
module tb;
  import rcos_pkg::*;
  logic clk_in = 0, rst_n_in = 0, avs_read_in = 0, avs_write_in = 0, avs_waitrequest_out;
  logic sys_mux_16m_mode_out;
  logic [7:0] avs_address_in = 0, channel_clock_in = 0;
  logic [7:0] m[5] = '{8'h21, 8'h43, 8'h65, 8'h07, 8'h00};
  logic [7:0] k[5] = '{8'h77, 8'h77, 8'h77, 8'h17, 8'h01};
  logic [31:0] avs_writedata_in = 0, avs_readdata_out, rdata, lfsr = 32'h1a2882ef;
  logic [3:0] avs_byteenable_in = 0;
  logic [6:0] seen;
  logic rate_ok;
  logic [1:0] system_data_rate_field = 2'b00;
  wire logic [6:0] outs;
  int fails = 0, comparisons = 0, cyc = 0, i, n;
  rcos_select u_dut (.clk_in, .rst_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
    .channel_clock_in, .sys_mux_16m_mode_out, .recovered_clock_out_2(outs[0]),
    .recovered_clock_out_3(outs[1]), .recovered_clock_out_4(outs[2]),
    .recovered_clock_out_5(outs[3]), .recovered_clock_out_6(outs[4]),
    .recovered_clock_out_7(outs[5]), .recovered_clock_out_8(outs[6]));
  rcos_sys_sink u_sink (.clk_in, .clocks_in(outs), .mux_mode_in(sys_mux_16m_mode_out),
    .rate_field_in(system_data_rate_field), .seen_out(seen), .rate_ok_out(rate_ok));
  initial forever #4 clk_in = ~clk_in;
  function automatic logic [31:0] next_lfsr(input logic [31:0] v);
    next_lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic give_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    avs_read_in <= !w;
    avs_write_in <= w;
    avs_address_in <= a;
    avs_writedata_in <= d;
    @(posedge clk_in);
    while (avs_waitrequest_out !== 1'b0)
      @(posedge clk_in);
    rdata = avs_readdata_out;
    avs_read_in <= 0;
    avs_write_in <= 0;
  endtask
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc > 5000)
    begin
      fails++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1;
    for (i = 0; i < 5; i++)
    begin
      bus(0, 8'hd3 + 8'(i), 0);
      check("reset", rdata, m[i]);
    end
    bus(0, 8'h10, 0);
    check("unmapped", rdata, 0);
    for (i = 0; i < 40; i++)
    begin
      lfsr = next_lfsr(lfsr);
      avs_byteenable_in <= {3'h7, lfsr[9] | i[0]};
      bus(1, 8'hd3 + 8'(i % 5), lfsr);
      if (avs_byteenable_in[0])
        m[i % 5] = lfsr[7:0] & k[i % 5];
      if (m[3][4])
        system_data_rate_field <= 2'b11;
      bus(0, 8'hd3 + 8'(i % 5), 0);
      check("readback", rdata, m[i % 5]);
      channel_clock_in <= lfsr[23:16];
      repeat (5) @(posedge clk_in);
      for (n = 2; n < 9; n++)
        check("clock", seen[n - 2], channel_clock_in[m[4][0] ? n - 1 :
          3'(m[(n - 2) / 2] >> (n % 2 * 4))]);
      check("mux", sys_mux_16m_mode_out, m[3][4]);
      check("rate", rate_ok, 1);
    end
    give_verdict();
  end
endmodule
